// >>> logic/srp_clk_if.sv
// carrier between the receive core and its clock generator
`timescale 1ns/100ps
interface srp_clk_if;
  logic io_mode;
  logic clock_direction_select;
  logic clock_edge_select;
  logic [1:0] uart_clock_source_select;
  logic baud_tick;
  logic timer_tick;
  logic sclk_sync;
  logic sclk_run;
  logic os_tick;
  logic io_tick;
  logic sclk_out;
  modport gen (
    input io_mode, clock_direction_select, clock_edge_select, uart_clock_source_select,
    input baud_tick, timer_tick, sclk_sync, sclk_run,
    output os_tick, io_tick, sclk_out
  );
  modport core (
    output io_mode, clock_direction_select, clock_edge_select, uart_clock_source_select,
    output baud_tick, timer_tick, sclk_sync, sclk_run,
    input os_tick, io_tick, sclk_out
  );
endinterface

// >>> logic/srp_clkgen.sv
// serial clock generation: oversample tick and I/O sample tick
`timescale 1ns/100ps
module srp_clkgen
  import srp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // core side
  srp_clk_if.gen ck
);
  logic half_r;
  logic sclk_out_r;
  logic sclk_prev_r;
  logic pin_rise;
  logic pin_fall;

  assign pin_rise = ck.sclk_sync & ~sclk_prev_r;
  assign pin_fall = ~ck.sclk_sync & sclk_prev_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      half_r <= 1'b0;
      sclk_prev_r <= 1'b1;
    end else begin
      half_r <= ~half_r;
      sclk_prev_r <= ck.sclk_sync;
    end
  end

  // driven clock idles high; halves baud ticks while running
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclk_out_r <= 1'b1;
    end else if (!ck.sclk_run) begin
      if (ck.baud_tick && !sclk_out_r) begin
        sclk_out_r <= 1'b1;
      end
    end else if (ck.baud_tick) begin
      sclk_out_r <= ~sclk_out_r;
    end
  end

  assign ck.sclk_out = sclk_out_r;

  always_comb begin
    ck.os_tick = 1'b0;
    ck.io_tick = 1'b0;
    if (ck.io_mode) begin
      if (!ck.clock_direction_select) begin
        ck.io_tick = ck.sclk_run & ck.baud_tick & ~sclk_out_r;
      end else begin
        ck.io_tick = ck.clock_edge_select ? pin_fall : pin_rise;
      end
    end else begin
      unique case (ck.uart_clock_source_select)
        SRP_SRC_BAUD: ck.os_tick = ck.baud_tick;
        SRP_SRC_SYS_HALF: ck.os_tick = half_r;
        SRP_SRC_TIMER: ck.os_tick = ck.timer_tick;
        SRP_SRC_PIN: ck.os_tick = pin_rise;
      endcase
    end
  end
endmodule

// >>> logic/srp_fifo.sv
// four-entry receive FIFO
`timescale 1ns/100ps
module srp_fifo
  import srp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // control
  input wire logic clr,
  input wire logic push,
  input wire logic [SRP_FRAME_W-1:0] din,
  input wire logic pop,
  // state
  output logic [SRP_FRAME_W-1:0] dout,
  output logic [2:0] count,
  output logic full,
  output logic empty
);
  logic [SRP_FRAME_W-1:0] mem [SRP_FIFO_DEPTH];
  logic [SRP_FIFO_AW-1:0] wr_ptr_r;
  logic [SRP_FIFO_AW-1:0] rd_ptr_r;
  logic [2:0] count_r;
  logic do_push;
  logic do_pop;

  assign full = (count_r == SRP_FIFO_FULL_CNT);
  assign empty = (count_r == 3'h0);
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign dout = mem[rd_ptr_r];
  assign count = count_r;

  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= din;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= 3'h0;
    end else if (clr) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= 3'h0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 2'h1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 2'h1;
      end
      if (do_push && !do_pop) begin
        count_r <= count_r + 3'h1;
      end else if (do_pop && !do_push) begin
        count_r <= count_r - 3'h1;
      end
    end
  end
endmodule

// >>> logic/srp_pkg.sv
// constants and helpers of the serial receive path
// Behaviour
// - clock-out I/O mode: shift clock is baud/2
// - clock-in I/O mode: basic clock from chosen edges
// - UART oversample clock chosen from four sources
// - 4-bit counter, sixteen pulses per bit
// - sample pulses 7,8,9, majority decides bit
// - clock-out mode samples on driven rising edge
// - clock-in mode samples on selected clock edge
// - UART frame starts after valid start bit
// - frame to second buffer, full flag set
// - interrupt on buffer entry or FIFO level
// - one read port; read clears full flag
// - shift register accepts frames while unread
// - double buffer switchable only in clock-out mode
// - no buffers: clock stops per frame, read restarts
// - double buffer: stop when both full, read resumes
// - FIFO stall; auto-disable clears receive enable
// - unread second buffer: overrun, new frame dropped
// - full FIFO: second buffer overwritten, FIFO overrun, FIFO kept
// - parity or ninth data bit stored
// - wake-up filter: interrupt only if ninth bit 1; with FIFO on the level interrupt ignores the filter
// - 4-byte FIFO; software also enables double buffer
// - fill-level code 00 means four bytes
package srp_pkg;
  // =====================================================
  // oversample counter
  localparam logic [3:0] SRP_VOTE_FIRST = 4'h6;
  localparam logic [3:0] SRP_VOTE_MID = 4'h7;
  localparam logic [3:0] SRP_VOTE_LAST = 4'h8;
  localparam logic [3:0] SRP_BIT_END = 4'hf;
  localparam logic [3:0] SRP_START_CNT = 4'h1;
  // =====================================================
  // frame and FIFO shape
  localparam int SRP_FRAME_W = 9;
  localparam logic [3:0] SRP_IO_LAST_BIT = 4'h7;
  localparam logic [3:0] SRP_UART8_LAST_BIT = 4'h7;
  localparam logic [3:0] SRP_UART9_LAST_BIT = 4'h8;
  localparam int SRP_FIFO_DEPTH = 4;
  localparam int SRP_FIFO_AW = 2;
  localparam logic [2:0] SRP_FIFO_FULL_CNT = 3'h4;
  // =====================================================
  // clock source and mode codes
  localparam logic [1:0] SRP_SRC_BAUD = 2'h0;
  localparam logic [1:0] SRP_SRC_SYS_HALF = 2'h1;
  localparam logic [1:0] SRP_SRC_TIMER = 2'h2;
  localparam logic [1:0] SRP_SRC_PIN = 2'h3;
  localparam logic [1:0] SRP_DPX_HALF_RX = 2'h1;
  localparam logic [1:0] SRP_DPX_FULL = 2'h3;
  localparam logic [2:0] SRP_LEVEL_FOUR_CODE = 3'h0;

  typedef enum logic [1:0] {SRP_IDLE, SRP_START, SRP_DATA, SRP_STOP} srp_state_type;

  // fill level code to byte count
  function automatic logic [2:0] srp_level(input logic [2:0] code);
    if (code == SRP_LEVEL_FOUR_CODE || code > SRP_FIFO_FULL_CNT) begin
      srp_level = SRP_FIFO_FULL_CNT;
    end else begin
      srp_level = code;
    end
  endfunction

  // majority of three samples
  function automatic logic srp_vote(input logic a, input logic b, input logic c);
    srp_vote = (a & b) | (a & c) | (b & c);
  endfunction
endpackage

// >>> logic/srp_top.sv
// receive path of a UART / clocked I/O serial channel
`timescale 1ns/100ps
module srp_top
  import srp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // serial pins
  input wire logic serial_receive_pin,
  input wire logic serial_clock_pin,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  // clock sources, same domain
  input wire logic baud_tick,
  input wire logic timer_channel_four_tick,
  // mode configuration
  input wire logic io_mode,
  input wire logic clock_direction_select,
  input wire logic clock_edge_select,
  input wire logic [1:0] uart_clock_source_select,
  input wire logic nine_bit_mode,
  input wire logic parity_enable,
  input wire logic wakeup_filter_enable,
  input wire logic double_buffer_enable,
  input wire logic fifo_config_bit,
  input wire logic [1:0] duplex_mode_field,
  input wire logic [2:0] receive_fill_level,
  input wire logic receive_fifo_stop_select,
  input wire logic auto_disable_enable,
  // receive enable
  input wire logic receive_enable_write,
  input wire logic receive_enable_wdata,
  output logic receive_enable_bit,
  // cpu access
  input wire logic data_read,
  input wire logic control_read,
  input wire logic fifo_clear,
  output logic [7:0] data_buffer_port,
  // status
  output logic receive_full_flag,
  output logic overrun_error_flag,
  output logic fifo_overrun_flag,
  output logic ninth_receive_bit,
  output logic [2:0] fifo_level,
  output logic receive_interrupt
);
  // =====================================================
  // pin synchronisers
  logic rx_meta_r;
  logic rx_sync_r;
  logic sclk_meta_r;
  logic sclk_sync_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      sclk_meta_r <= 1'b1;
      sclk_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= serial_receive_pin;
      rx_sync_r <= rx_meta_r;
      sclk_meta_r <= serial_clock_pin;
      sclk_sync_r <= sclk_meta_r;
    end
  end

  // =====================================================
  // mode decode
  logic clk_out_mode;
  logic fifo_on;
  logic dbl_on;
  logic [2:0] level_cnt;

  assign clk_out_mode = io_mode & ~clock_direction_select;
  assign fifo_on = fifo_config_bit &
                   (duplex_mode_field == SRP_DPX_HALF_RX || duplex_mode_field == SRP_DPX_FULL);
  assign dbl_on = clk_out_mode ? double_buffer_enable : 1'b1;
  assign level_cnt = srp_level(receive_fill_level);

  // =====================================================
  // clock generator
  srp_clk_if ck ();
  logic shift_hold_r;
  logic rx_en_r;

  assign ck.io_mode = io_mode;
  assign ck.clock_direction_select = clock_direction_select;
  assign ck.clock_edge_select = clock_edge_select;
  assign ck.uart_clock_source_select = uart_clock_source_select;
  assign ck.baud_tick = baud_tick;
  assign ck.timer_tick = timer_channel_four_tick;
  assign ck.sclk_sync = sclk_sync_r;
  assign ck.sclk_run = clk_out_mode & rx_en_r & ~shift_hold_r;

  srp_clkgen u_clkgen (
    .ref_clk(ref_clk),
    .reset(reset),
    .ck(ck.gen)
  );

  assign serial_clock_out = ck.sclk_out;
  assign serial_clock_oe = clk_out_mode;

  // =====================================================
  // receive sequencer
  srp_state_type state_r;
  logic [3:0] os_cnt_r;
  logic [3:0] bit_idx_r;
  logic [1:0] votes_r;
  logic [SRP_FRAME_W-1:0] shift_r;
  logic bit_val;
  logic [3:0] uart_last_bit;
  logic io_shift;
  logic frame_done;

  assign bit_val = srp_vote(votes_r[1], votes_r[0], rx_sync_r);
  assign uart_last_bit = (nine_bit_mode | parity_enable) ? SRP_UART9_LAST_BIT : SRP_UART8_LAST_BIT;
  assign io_shift = io_mode & rx_en_r & ck.io_tick & ~shift_hold_r;
  assign frame_done = io_mode ? (io_shift && bit_idx_r == SRP_IO_LAST_BIT)
                              : (ck.os_tick && state_r == SRP_STOP && os_cnt_r == SRP_VOTE_LAST);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= SRP_IDLE;
      os_cnt_r <= 4'h0;
      bit_idx_r <= 4'h0;
      votes_r <= 2'h0;
      shift_r <= '0;
    end else if (io_mode) begin
      state_r <= SRP_IDLE;
      if (!rx_en_r) begin
        bit_idx_r <= 4'h0;
      end else if (io_shift) begin
        shift_r[bit_idx_r] <= rx_sync_r;
        if (bit_idx_r == SRP_IO_LAST_BIT) begin
          shift_r[SRP_FRAME_W-1] <= 1'b0;
          bit_idx_r <= 4'h0;
        end else begin
          bit_idx_r <= bit_idx_r + 4'h1;
        end
      end
    end else if (!rx_en_r) begin
      state_r <= SRP_IDLE;
    end else if (ck.os_tick) begin
      if (state_r == SRP_IDLE) begin
        if (!rx_sync_r) begin
          state_r <= SRP_START;
          os_cnt_r <= SRP_START_CNT;
          bit_idx_r <= 4'h0;
        end
      end else begin
        os_cnt_r <= os_cnt_r + 4'h1;
        if (os_cnt_r == SRP_VOTE_FIRST) begin
          votes_r[1] <= rx_sync_r;
        end
        if (os_cnt_r == SRP_VOTE_MID) begin
          votes_r[0] <= rx_sync_r;
        end
        if (os_cnt_r == SRP_VOTE_LAST) begin
          unique case (state_r)
            SRP_START: begin
              if (bit_val) begin
                state_r <= SRP_IDLE;
              end
            end
            SRP_DATA: begin
              shift_r[bit_idx_r] <= bit_val;
            end
            SRP_STOP: begin
              state_r <= SRP_IDLE;
            end
            SRP_IDLE: begin
            end
          endcase
        end
        if (os_cnt_r == SRP_BIT_END) begin
          if (state_r == SRP_START) begin
            state_r <= SRP_DATA;
            if (!(nine_bit_mode | parity_enable)) begin
              shift_r[SRP_FRAME_W-1] <= 1'b0;
            end
          end else if (state_r == SRP_DATA) begin
            if (bit_idx_r == uart_last_bit) begin
              state_r <= SRP_STOP;
            end else begin
              bit_idx_r <= bit_idx_r + 4'h1;
            end
          end
        end
      end
    end
  end

  // =====================================================
  // FIFO
  logic fifo_push;
  logic [SRP_FRAME_W-1:0] fifo_din;
  logic fifo_pop;
  logic [SRP_FRAME_W-1:0] fifo_dout;
  logic [2:0] fifo_count;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_block;
  logic [SRP_FRAME_W-1:0] buf2_r;
  logic buf2_valid_r;

  assign fifo_block = (clk_out_mode && receive_fifo_stop_select) ? (fifo_count >= level_cnt) : fifo_full;
  assign fifo_pop = data_read & fifo_on;

  always_comb begin
    fifo_push = 1'b0;
    fifo_din = shift_r;
    if (fifo_on && !fifo_block) begin
      if (buf2_valid_r) begin
        fifo_push = 1'b1;
        fifo_din = buf2_r;
      end else if (frame_done) begin
        fifo_push = 1'b1;
      end
    end
  end

  srp_fifo u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .clr(fifo_clear),
    .push(fifo_push),
    .din(fifo_din),
    .pop(fifo_pop),
    .dout(fifo_dout),
    .count(fifo_count),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // =====================================================
  // second buffer and first-buffer hold
  logic buf2_load;
  logic [SRP_FRAME_W-1:0] buf2_src;
  logic overrun_set;
  logic fifo_ovr_set;
  logic hold_set;
  logic hold_release;
  logic buf2_free;

  always_comb begin
    buf2_load = 1'b0;
    buf2_src = shift_r;
    overrun_set = 1'b0;
    fifo_ovr_set = 1'b0;
    hold_set = 1'b0;
    hold_release = 1'b0;
    buf2_free = 1'b0;
    if (fifo_on) begin
      if (fifo_push && buf2_valid_r) begin
        buf2_free = 1'b1;
        if (frame_done || shift_hold_r) begin
          buf2_load = 1'b1;
          hold_release = shift_hold_r;
        end
      end else if (frame_done && fifo_block) begin
        if (!buf2_valid_r) begin
          buf2_load = 1'b1;
        end else if (clk_out_mode) begin
          hold_set = 1'b1;
        end else begin
          buf2_load = 1'b1;
          fifo_ovr_set = 1'b1;
        end
      end
    end else if (clk_out_mode && !dbl_on) begin
      hold_set = frame_done;
      hold_release = data_read;
    end else begin
      if (data_read) begin
        if (shift_hold_r) begin
          buf2_load = 1'b1;
          hold_release = 1'b1;
        end else begin
          buf2_free = 1'b1;
        end
      end
      if (frame_done) begin
        if (!buf2_valid_r || (data_read && !shift_hold_r)) begin
          buf2_load = 1'b1;
          buf2_free = 1'b0;
        end else if (clk_out_mode) begin
          hold_set = 1'b1;
        end else begin
          overrun_set = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      buf2_r <= '0;
      buf2_valid_r <= 1'b0;
    end else if (buf2_load) begin
      buf2_r <= buf2_src;
      buf2_valid_r <= 1'b1;
    end else if (buf2_free) begin
      buf2_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      shift_hold_r <= 1'b0;
    end else if (hold_set) begin
      shift_hold_r <= 1'b1;
    end else if (hold_release || !rx_en_r && !clk_out_mode) begin
      shift_hold_r <= 1'b0;
    end
  end

  // =====================================================
  // receive enable with auto-disable
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rx_en_r <= 1'b0;
    end else if (hold_set && fifo_on && auto_disable_enable) begin
      rx_en_r <= 1'b0;
    end else if (receive_enable_write) begin
      rx_en_r <= receive_enable_wdata;
    end
  end

  // =====================================================
  // flags
  logic ninth_r;
  logic ovr_r;
  logic fovr_r;
  logic full_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ninth_r <= 1'b0;
    end else if (buf2_load && !fifo_on) begin
      ninth_r <= buf2_src[SRP_FRAME_W-1];
    end else if (fifo_on && (fifo_push || buf2_load)) begin
      ninth_r <= buf2_load ? buf2_src[SRP_FRAME_W-1] : fifo_din[SRP_FRAME_W-1];
    end else if (hold_set && !dbl_on) begin
      ninth_r <= shift_r[SRP_FRAME_W-1];
    end
  end

  // set wins over a clear by control read
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ovr_r <= 1'b0;
    end else if (overrun_set) begin
      ovr_r <= 1'b1;
    end else if (control_read) begin
      ovr_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fovr_r <= 1'b0;
    end else if (fifo_ovr_set) begin
      fovr_r <= 1'b1;
    end else if (fifo_clear) begin
      fovr_r <= 1'b0;
    end
  end

  // with FIFO on the flag is held clear and never set
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      full_r <= 1'b0;
    end else if (fifo_on) begin
      full_r <= 1'b0;
    end else begin
      full_r <= buf2_load ? 1'b1 : (buf2_free ? 1'b0 : buf2_valid_r);
    end
  end

  // =====================================================
  // read data and interrupt
  logic [7:0] rd_data_r;
  logic int_r;
  logic wake_pass;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data_r <= 8'h00;
    end else if (fifo_on) begin
      rd_data_r <= fifo_dout[7:0];
    end else if (clk_out_mode && !dbl_on) begin
      rd_data_r <= shift_r[7:0];
    end else begin
      rd_data_r <= buf2_r[7:0];
    end
  end

  assign wake_pass = ~(nine_bit_mode & wakeup_filter_enable & ~io_mode) | buf2_src[SRP_FRAME_W-1];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      int_r <= 1'b0;
    end else if (fifo_on) begin
      int_r <= fifo_push && !fifo_full && (fifo_count + 3'h1 == level_cnt);
    end else if (clk_out_mode && !dbl_on) begin
      int_r <= hold_set;
    end else begin
      int_r <= buf2_load & wake_pass;
    end
  end

  assign receive_enable_bit = rx_en_r;
  assign data_buffer_port = rd_data_r;
  assign receive_full_flag = full_r;
  assign overrun_error_flag = ovr_r;
  assign fifo_overrun_flag = fovr_r;
  assign ninth_receive_bit = ninth_r;
  assign fifo_level = fifo_count;
  assign receive_interrupt = int_r;
endmodule

// >>> verif/srp_assertions.sv
// assertion checker of the serial receive path
`timescale 1ns/100ps
module srp_rx_assertions
  import srp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // inputs
  input wire logic baud_tick,
  input wire logic io_mode,
  input wire logic clock_direction_select,
  input wire logic wakeup_filter_enable,
  input wire logic fifo_config_bit,
  input wire logic [1:0] duplex_mode_field,
  input wire logic data_read,
  // outputs
  input wire logic serial_clock_out,
  input wire logic serial_clock_oe,
  input wire logic [7:0] data_buffer_port,
  input wire logic receive_full_flag,
  input wire logic overrun_error_flag,
  input wire logic fifo_overrun_flag,
  input wire logic ninth_receive_bit,
  input wire logic [2:0] fifo_level,
  input wire logic receive_interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic fifo_on;
  assign fifo_on = fifo_config_bit & duplex_mode_field[0];
  sequence s_read;
    data_read && !fifo_on && receive_full_flag;
  endsequence
  chk_int_pulse: assert property (receive_interrupt |=> !receive_interrupt)
    else $error("interrupt wider than one cycle");
  chk_read_clears: assert property (s_read |=> !receive_full_flag || receive_interrupt)
    else $error("read left full flag set");
  chk_fifo_noflag: assert property (fifo_on && $past(fifo_on) |-> !receive_full_flag)
    else $error("full flag set in fifo mode");
  chk_fifo_cap: assert property (fifo_level <= SRP_FIFO_FULL_CNT)
    else $error("fifo level above depth");
  chk_reset_clear: assert property ($fell(reset) |-> !receive_full_flag && !overrun_error_flag
    && !fifo_overrun_flag && fifo_level == 3'h0) else $error("flags not cleared by reset");
  chk_oe_mode: assert property (serial_clock_oe == (io_mode && !clock_direction_select))
    else $error("clock enable wrong for mode");
  chk_clk_step: assert property ($changed(serial_clock_out) |-> $past(baud_tick) && serial_clock_oe)
    else $error("shift clock moved without tick");
  chk_overrun_keep: assert property ($rose(overrun_error_flag) |-> $stable(ninth_receive_bit)
    ##1 $stable(data_buffer_port)) else $error("overrun changed buffer");
  chk_fifo_ovr: assert property ($rose(fifo_overrun_flag) |-> fifo_level == SRP_FIFO_FULL_CNT)
    else $error("fifo overrun while not full");
  chk_full_int: assert property ($rose(receive_full_flag) && !wakeup_filter_enable |-> receive_interrupt)
    else $error("no interrupt on buffer entry");
endmodule
bind srp_top srp_rx_assertions u_chk (.*);

// >>> verif/srp_uart_tx.sv
// behavioural remote uart transmitter
`timescale 1ns/100ps
module srp_uart_tx #(
  parameter int BIT_CYC = 32
) (
  // clock
  input wire logic ref_clk,
  // shift clock driven by the block in clock-out I/O mode
  input wire logic sclk,
  // serial line, idles high
  output logic line
);
  initial line = 1'b1;
  // start, data lsb first, stop
  task automatic send(input logic [8:0] d, input int nb);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    f[9] = (nb == 9) ? d[8] : 1'b1;
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge ref_clk);
      #1 line = f[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk);
    end
  endtask
  // clocked peripheral: bit 0 first, next bit after each rising shift clock
  task automatic shift_out(input logic [7:0] d);
    line = d[0];
    for (int i = 1; i < 8; i++) begin
      @(posedge sclk);
      #1 line = d[i];
    end
    @(posedge sclk);
    #1 line = 1'b1;
  endtask
  // low pulse too short for a start bit
  task automatic glitch();
    @(posedge ref_clk);
    #1 line = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 line = 1'b1;
  endtask
endmodule

// >>> verif/tb.sv
// self-checking bench of the serial receive path
`timescale 1ns/100ps
module tb;
  import srp_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, serial_clock_pin = 1'b1, baud_tick = 1'b0;
  logic timer_channel_four_tick = 1'b0, io_mode = 1'b0, clock_direction_select = 1'b0;
  logic clock_edge_select = 1'b0, nine_bit_mode = 1'b0, parity_enable = 1'b0;
  logic wakeup_filter_enable = 1'b0, double_buffer_enable = 1'b1, fifo_config_bit = 1'b0;
  logic receive_fifo_stop_select = 1'b0, auto_disable_enable = 1'b0, receive_enable_write = 1'b0;
  logic receive_enable_wdata = 1'b0, data_read = 1'b0, control_read = 1'b0, fifo_clear = 1'b0;
  logic [1:0] uart_clock_source_select = SRP_SRC_BAUD, duplex_mode_field = SRP_DPX_HALF_RX;
  logic [2:0] receive_fill_level = SRP_LEVEL_FOUR_CODE, fifo_level;
  logic serial_receive_pin, serial_clock_out, serial_clock_oe, receive_enable_bit;
  logic receive_full_flag, overrun_error_flag, fifo_overrun_flag, ninth_receive_bit, receive_interrupt;
  logic [7:0] data_buffer_port;
  int miscompares = 0, n_tests = 0, n_int = 0, cycles = 0;
  srp_top u_dut (.*);
  srp_uart_tx u_tx (.ref_clk, .sclk(serial_clock_out), .line(serial_receive_pin));
  always #50 ref_clk = ~ref_clk;
  // all four sources tick every other cycle
  always @(posedge ref_clk) begin
    #1;
    baud_tick = ~baud_tick;
    timer_channel_four_tick = ~timer_channel_four_tick;
    serial_clock_pin = ~serial_clock_pin;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (receive_interrupt === 1'b1) n_int++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic en(input logic v);
    receive_enable_wdata = v;
    pulse(receive_enable_write);
  endtask
  task automatic rx(input logic [8:0] d, input int nb);
    u_tx.send(d, nb);
    cyc(4);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 reset = 1'b0;
    chk(receive_full_flag, 1'b0);
    chk(data_buffer_port, 8'h00);
    chk(fifo_level, 3'h0);
    cyc(3);
    en(1'b1);
    chk(receive_enable_bit, 1'b1);
    u_tx.glitch();
    cyc(40);
    chk(9'(n_int), 9'h000);
    rx(9'h0a5, 8);
    chk(receive_full_flag, 1'b1);
    chk(data_buffer_port, 8'ha5);
    chk(9'(n_int), 9'h001);
    rx(9'h03c, 8);
    chk(overrun_error_flag, 1'b1);
    chk(data_buffer_port, 8'ha5);
    pulse(data_read);
    pulse(control_read);
    cyc(1);
    chk(receive_full_flag, 1'b0);
    chk(overrun_error_flag, 1'b0);
    en(1'b0);
    nine_bit_mode = 1'b1;
    wakeup_filter_enable = 1'b1;
    uart_clock_source_select = SRP_SRC_TIMER;
    cyc(1);
    en(1'b1);
    rx(9'h055, 9);
    chk(9'(n_int), 9'h001);
    chk(ninth_receive_bit, 1'b0);
    pulse(data_read);
    rx(9'h1aa, 9);
    chk(9'(n_int), 9'h002);
    chk({ninth_receive_bit, data_buffer_port}, 9'h1aa);
    pulse(data_read);
    en(1'b0);
    nine_bit_mode = 1'b0;
    parity_enable = 1'b1;
    wakeup_filter_enable = 1'b0;
    uart_clock_source_select = SRP_SRC_SYS_HALF;
    cyc(1);
    en(1'b1);
    rx(9'h1c3, 9);
    chk({ninth_receive_bit, data_buffer_port}, 9'h1c3);
    chk(^{ninth_receive_bit, data_buffer_port}, 1'b1);
    chk(9'(n_int), 9'h003);
    pulse(data_read);
    en(1'b0);
    parity_enable = 1'b0;
    fifo_config_bit = 1'b1;
    duplex_mode_field = SRP_DPX_FULL;
    double_buffer_enable = 1'b1;
    uart_clock_source_select = SRP_SRC_PIN;
    pulse(fifo_clear);
    en(1'b1);
    for (int i = 0; i < 4; i++) begin
      rx(9'h010 + 9'(i), 8);
    end
    chk(fifo_level, 3'h4);
    chk(9'(n_int), 9'h004);
    chk(receive_full_flag, 1'b0);
    rx(9'h077, 8);
    rx(9'h066, 8);
    chk(fifo_overrun_flag, 1'b1);
    chk(data_buffer_port, 8'h10);
    pulse(data_read);
    cyc(2);
    chk(data_buffer_port, 8'h11);
    en(1'b0);
    fifo_config_bit = 1'b0;
    double_buffer_enable = 1'b0;
    io_mode = 1'b1;
    cyc(1);
    fork
      u_tx.shift_out(8'h96);
      en(1'b1);
    join
    cyc(8);
    chk(serial_clock_oe, 1'b1);
    chk(serial_clock_out, 1'b1);
    chk(data_buffer_port, 8'h96);
    chk(9'(n_int), 9'h006);
    pulse(control_read);
    chk(overrun_error_flag, 1'b0);
    end_of_test();
  end
endmodule
